// file: hw/ascb_top.sv
// Setup configuration bank: four setup registers over AXI4-Lite, the
// controls of the setup in use, and result coding with open-wire check.
// Assumes conv_setup_sel and raw_* come from logic on sys_clk.
`timescale 1ns/1ps
module ascb_top
   import ascb_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [1:0] conv_setup_sel,
   input wire logic raw_valid,
   input wire logic [23:0] raw_data,
   input wire logic open_wire_pin,
   output ascb_ctl_t ctl,
   output logic result_valid,
   output logic [23:0] result_data
);

   function automatic logic is_setup(input logic [5:0] idx);
      is_setup = (idx >= ASCB_IDX_SETUP0) && (idx <= ASCB_IDX_SETUP3);
   endfunction : is_setup

   // ----------------------------------------------------------------
   // Write channel
   // ----------------------------------------------------------------
   logic [15:0] setup_reg [ASCB_NUM_SETUPS];
   logic [5:0] aw_idx_reg;
   logic aw_got_reg;
   logic [15:0] w_data_reg;
   logic [1:0] w_strb_reg;
   logic w_got_reg;
   logic awready_reg;
   logic wready_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;

   wire aw_take = s_axi_awvalid & awready_reg;
   wire w_take = s_axi_wvalid & wready_reg;
   wire write_do = aw_got_reg & w_got_reg & ~bvalid_reg;
   wire write_hit = is_setup(aw_idx_reg);
   wire [1:0] write_sel = aw_idx_reg[1:0];
   wire [15:0] byte_mask = {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
   wire aw_got_next = (aw_got_reg | aw_take) & ~write_do;
   wire w_got_next = (w_got_reg | w_take) & ~write_do;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         aw_got_reg <= 1'b0;
         w_got_reg <= 1'b0;
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         aw_idx_reg <= 6'h00;
         w_data_reg <= 16'h0000;
         w_strb_reg <= 2'h0;
      end else begin
         aw_got_reg <= aw_got_next;
         w_got_reg <= w_got_next;
         // One address and one data word held at most
         awready_reg <= ~aw_got_next;
         wready_reg <= ~w_got_next;
         if (aw_take) begin
            aw_idx_reg <= s_axi_awaddr[7:2];
         end
         if (w_take) begin
            w_data_reg <= s_axi_wdata[15:0];
            w_strb_reg <= s_axi_wstrb[1:0];
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= ASCB_RESP_OKAY;
      end else if (write_do) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= write_hit ? ASCB_RESP_OKAY : ASCB_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Setup registers
   // ----------------------------------------------------------------
   genvar gi;
      for (gi = 0; gi < ASCB_NUM_SETUPS; gi++) begin : g_setup
         wire hit = write_do & write_hit & (write_sel == 2'(gi));
         wire [15:0] merged = ((setup_reg[gi] & ~byte_mask) |
                               (w_data_reg & byte_mask)) & ASCB_SETUP_RW_MASK;
         always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
               setup_reg[gi] <= ASCB_SETUP_RESET;
            end else if (hit) begin
               setup_reg[gi] <= merged;
            end
         end
      end

   // ----------------------------------------------------------------
   // Read channel
   // ----------------------------------------------------------------
   logic ow_meta_reg;
   logic ow_sync_reg;
   logic arready_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;

   wire ar_take = s_axi_arvalid & arready_reg;
   wire [5:0] ar_idx = s_axi_araddr[7:2];
   wire [31:0] status_word = {29'h0, ow_sync_reg, conv_setup_sel};
   wire [31:0] rd_word = is_setup(ar_idx) ?
                         {16'h0000, setup_reg[ar_idx[1:0]]} :
                         (ar_idx == ASCB_IDX_STATUS) ? status_word : 32'h0;
   wire rd_ok = is_setup(ar_idx) | (ar_idx == ASCB_IDX_STATUS);

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0;
         rresp_reg <= ASCB_RESP_OKAY;
      end else if (ar_take) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b1;
         rdata_reg <= rd_word;
         rresp_reg <= rd_ok ? ASCB_RESP_OKAY : ASCB_RESP_SLVERR;
      end else if (rvalid_reg & s_axi_rready) begin
         rvalid_reg <= 1'b0;
         arready_reg <= 1'b1;
      end else if (~rvalid_reg) begin
         arready_reg <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Controls of the setup in use
   // ----------------------------------------------------------------
   ascb_ctl_t dec [ASCB_NUM_SETUPS];
   ascb_ctl_t ctl_reg;
   logic res_valid_reg;
   logic [23:0] res_data_reg;

      for (gi = 0; gi < ASCB_NUM_SETUPS; gi++) begin : g_dec
         ascb_setup_decode u_dec (
            .setup_word(setup_reg[gi]),
            .ctl(dec[gi])
         );
      end

   // Open-wire comparator sits in the analog domain; two-stage sync
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ow_meta_reg <= 1'b0;
         ow_sync_reg <= 1'b0;
      end else begin
         ow_meta_reg <= open_wire_pin;
         ow_sync_reg <= ow_meta_reg;
      end
   end

   wire force_full = ctl_reg.burnout & ow_sync_reg;
   // offset binary flips the sign bit; unipolar clamps negatives
   wire [23:0] bipolar_code = {~raw_data[23], raw_data[22:0]};
   wire [23:0] unipolar_code = raw_data[23] ? 24'h000000 :
                               {raw_data[22:0], 1'b0};
   wire [23:0] res_next = force_full ? ASCB_FULL_SCALE :
                          ctl_reg.bipolar ? bipolar_code : unipolar_code;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ctl_reg <= '0;
         res_valid_reg <= 1'b0;
         res_data_reg <= 24'h000000;
      end else begin
         // live setting of the selected setup
         ctl_reg <= dec[conv_setup_sel];
         res_valid_reg <= raw_valid;
         if (raw_valid) begin
            res_data_reg <= res_next;
         end
      end
   end

   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
   assign ctl = ctl_reg;
   assign result_valid = res_valid_reg;
   assign result_data = res_data_reg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence s_settled;
      !$past(rst) && !$past(write_do) && $stable(conv_setup_sel);
   endsequence
   wire [15:0] cur_setup = setup_reg[conv_setup_sel];
   property p_reserved_zero;
      @(posedge sys_clk) disable iff (rst)
         (setup_reg[write_sel] & ~ASCB_SETUP_RW_MASK) == 16'h0000;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved setup bits not zero");
   property p_full_write;
      @(posedge sys_clk) disable iff (rst)
         write_do && write_hit && w_strb_reg == 2'h3 |=>
            setup_reg[$past(write_sel)] ==
            ($past(w_data_reg) & ASCB_SETUP_RW_MASK);
   endproperty
   a_full_write: assert property (p_full_write)
      else $error("setup write not stored");
   property p_neg_buf;
      @(posedge sys_clk) disable iff (rst)
         s_settled |-> ctl.ain_buf_n == cur_setup[ASCB_BIT_AIN_BUF_N];
   endproperty
   a_neg_buf: assert property (p_neg_buf)
      else $error("negative input buffer wrong");
   property p_burnout;
      @(posedge sys_clk) disable iff (rst)
         s_settled |-> ctl.burnout == cur_setup[ASCB_BIT_BURNOUT];
   endproperty
   a_burnout: assert property (p_burnout)
      else $error("burnout enable wrong");
   property p_ref_sel;
      @(posedge sys_clk) disable iff (rst)
         s_settled |-> ctl.ref_sel == cur_setup[ASCB_REF_SEL_LSB +: 2];
   endproperty
   a_ref_sel: assert property (p_ref_sel)
      else $error("reference select wrong");
   property p_bufs;
      @(posedge sys_clk) disable iff (rst)
         s_settled |-> {ctl.ref_buf_p, ctl.ref_buf_n, ctl.ain_buf_p} ==
                       cur_setup[ASCB_BIT_REF_BUF_P -: 3];
   endproperty
   a_bufs: assert property (p_bufs)
      else $error("buffer enables wrong");
   sequence s_open_sample;
      raw_valid && ctl.burnout && ow_sync_reg;
   endsequence
   property p_open_full;
      @(posedge sys_clk) disable iff (rst)
         s_open_sample |=> result_valid && result_data == ASCB_FULL_SCALE;
   endproperty
   a_open_full: assert property (p_open_full)
      else $error("open wire not full scale");
   property p_bipolar;
      @(posedge sys_clk) disable iff (rst)
         raw_valid && ctl.bipolar && !(ctl.burnout && ow_sync_reg) |=>
            result_data == {~$past(raw_data[23]), $past(raw_data[22:0])};
   endproperty
   a_bipolar: assert property (p_bipolar)
      else $error("offset binary coding wrong");
   property p_apply_setup;
      @(posedge sys_clk) disable iff (rst)
         write_do && write_hit && w_strb_reg == 2'h3 &&
         conv_setup_sel == write_sel ##1 $stable(conv_setup_sel) |=>
            ctl.bipolar == $past(w_data_reg[ASCB_BIT_CODING], 2);
   endproperty
   a_apply_setup: assert property (p_apply_setup)
      else $error("new setup not applied");

endmodule : ascb_top

// file: hw/ascb_pkg.sv
// Constants and types for the converter setup configuration bank.
// Assumes one register clock domain and a 32-bit AXI4-Lite register port.
package ascb_pkg;

   // ----------------------------------------------------------------
   // Register map (indices; byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [5:0] ASCB_IDX_SETUP0 = 6'h20;
   localparam logic [5:0] ASCB_IDX_SETUP1 = 6'h21;
   localparam logic [5:0] ASCB_IDX_SETUP2 = 6'h22;
   localparam logic [5:0] ASCB_IDX_SETUP3 = 6'h23;
   localparam logic [5:0] ASCB_IDX_STATUS = 6'h24;
   localparam int ASCB_NUM_SETUPS = 4;

   // ----------------------------------------------------------------
   // Setup register layout
   // ----------------------------------------------------------------
   localparam logic [15:0] ASCB_SETUP_RESET = 16'h1320;
   localparam logic [15:0] ASCB_SETUP_RW_MASK = 16'h1FB0;
   localparam int ASCB_BIT_CODING = 12;
   localparam int ASCB_BIT_REF_BUF_P = 11;
   localparam int ASCB_BIT_REF_BUF_N = 10;
   localparam int ASCB_BIT_AIN_BUF_P = 9;
   localparam int ASCB_BIT_AIN_BUF_N = 8;
   localparam int ASCB_BIT_BURNOUT = 7;
   localparam int ASCB_REF_SEL_LSB = 4;

   // Reference source codes
   localparam logic [1:0] ASCB_REF_EXTERNAL = 2'h0;
   localparam logic [1:0] ASCB_REF_INTERNAL = 2'h2;
   localparam logic [1:0] ASCB_REF_SUPPLY = 2'h3;

   // ----------------------------------------------------------------
   // Result path
   // ----------------------------------------------------------------
   localparam int ASCB_RES_W = 24;
   localparam logic [23:0] ASCB_FULL_SCALE = 24'hFFFFFF;

   // AXI responses
   localparam logic [1:0] ASCB_RESP_OKAY = 2'h0;
   localparam logic [1:0] ASCB_RESP_SLVERR = 2'h2;

   // Analog controls applied for one setup
   typedef struct packed {
      logic bipolar;
      logic ref_buf_p;
      logic ref_buf_n;
      logic ain_buf_p;
      logic ain_buf_n;
      logic burnout;
      logic [1:0] ref_sel;
   } ascb_ctl_t;

endpackage : ascb_pkg

// file: hw/ascb_setup_decode.sv
// Decodes one setup register word into its analog control fields.
// Assumes reserved bits are already held at zero by the register file.
`timescale 1ns/1ps
module ascb_setup_decode
   import ascb_pkg::*;
(
   input wire logic [15:0] setup_word,
   output ascb_ctl_t ctl
);

   assign ctl.bipolar = setup_word[ASCB_BIT_CODING];
   assign ctl.ref_buf_p = setup_word[ASCB_BIT_REF_BUF_P];
   assign ctl.ref_buf_n = setup_word[ASCB_BIT_REF_BUF_N];
   assign ctl.ain_buf_p = setup_word[ASCB_BIT_AIN_BUF_P];
   assign ctl.ain_buf_n = setup_word[ASCB_BIT_AIN_BUF_N];
   assign ctl.burnout = setup_word[ASCB_BIT_BURNOUT];
   assign ctl.ref_sel = setup_word[ASCB_REF_SEL_LSB +: 2];

endmodule : ascb_setup_decode

// file: bench/ascb_host.sv
// Host controller model: AXI4-Lite master for the setup bank.
// Assumes the bench calls wr and rd one at a time, after reset.
`timescale 1ns/1ps
module ascb_host
   import ascb_pkg::*;
(
   input wire logic sys_clk,
   output logic [7:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   output logic [7:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
      {s_axi_arvalid, s_axi_rready} = '0;
   end
   // ----------------------------------------------------------------
   // Write: address and data offered together, each held until taken
   // ----------------------------------------------------------------
   task wr(input logic [5:0] idx, input logic [15:0] d,
           input logic keep_rsv, output logic [1:0] resp);
      @(posedge sys_clk);
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= {16'h0000, keep_rsv ? d : (d & ASCB_SETUP_RW_MASK)};
      s_axi_wstrb <= 4'hF;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge sys_clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && s_axi_bready) begin
            resp = s_axi_bresp;
            s_axi_bready <= 1'b0;
            break;
         end
      end
   endtask : wr
   task rd(input logic [5:0] idx, output logic [31:0] d,
           output logic [1:0] resp);
      @(posedge sys_clk);
      s_axi_araddr <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge sys_clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && s_axi_rready) begin
            d = s_axi_rdata;
            resp = s_axi_rresp;
            s_axi_rready <= 1'b0;
            break;
         end
      end
   endtask : rd
endmodule : ascb_host

// file: bench/tb_ascb_top.sv
// Self-checking bench for the setup bank: register access, controls
// of the selected setup and result coding. Host model drives the bus.
`timescale 1ns/1ps
module tb_ascb_top;
   import ascb_pkg::*;
   logic sys_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready, raw_valid;
   logic open_wire_pin, result_valid;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, conv_setup_sel, resp;
   logic [23:0] raw_data, result_data;
   ascb_ctl_t ctl;
   int n_fail = 0;
   int checked = 0;
   ascb_top i_ascb_top (.sys_clk(sys_clk), .rst(rst),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .conv_setup_sel(conv_setup_sel), .raw_valid(raw_valid),
      .raw_data(raw_data), .open_wire_pin(open_wire_pin), .ctl(ctl),
      .result_valid(result_valid), .result_data(result_data));
   ascb_host i_ascb_host (.sys_clk(sys_clk), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
   // ----------------------------------------------------------------
   // Clock, checks and shared steps
   // ----------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task end_of_test;
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_of_test
   task wr_ok(input logic [5:0] idx, input logic [15:0] d);
      i_ascb_host.wr(idx, d, 1'b0, resp);
      chk("bresp", ASCB_RESP_OKAY, resp);
   endtask : wr_ok
   task sel(input logic [1:0] s, input logic [7:0] exp);
      @(posedge sys_clk);
      conv_setup_sel <= s;
      repeat (3) @(posedge sys_clk);
      chk("ctl", exp, ctl);
   endtask : sel
   // Sample launched, result looked at in its single valid cycle
   task smp(input logic [23:0] d, input logic [23:0] exp);
      @(posedge sys_clk);
      raw_valid <= 1'b1;
      raw_data <= d;
      @(posedge sys_clk);
      raw_valid <= 1'b0;
      #1;
      chk("result_valid", 1, result_valid);
      chk("result_data", exp, result_data);
   endtask : smp
   initial begin
      #2_000_000;
      n_fail++;
      end_of_test();
   end
   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      rst = 1'b1;
      conv_setup_sel = 2'h0;
      raw_valid = 1'b0;
      raw_data = 24'h000000;
      open_wire_pin = 1'b0;
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      for (int i = 0; i < ASCB_NUM_SETUPS; i++) begin
         i_ascb_host.rd(ASCB_IDX_SETUP0 + 6'(i), rdat, resp);
         chk("setup reset", 32'h00001320, rdat);
         chk("rresp", ASCB_RESP_OKAY, resp);
      end
      i_ascb_host.wr(ASCB_IDX_SETUP1, 16'hFFFF, 1'b1, resp);
      i_ascb_host.rd(ASCB_IDX_SETUP1, rdat, resp);
      chk("reserved", 32'h00001FB0, rdat);
      sel(2'h1, 8'hFF);
      wr_ok(ASCB_IDX_SETUP1, 16'h1E20);
      sel(2'h1, 8'hF2);
      // internal reference also enabled outside this block
      for (int k = 0; k < 3; k++) begin
         logic [1:0] c;
         c = (k == 0) ? ASCB_REF_EXTERNAL :
             (k == 1) ? ASCB_REF_INTERNAL : ASCB_REF_SUPPLY;
         wr_ok(ASCB_IDX_SETUP2, 16'h1000 | (16'(c) << 4));
         sel(2'h2, {6'b100000, c});
      end
      smp(24'h000001, 24'h800001);
      wr_ok(ASCB_IDX_SETUP3, 16'h0020);
      sel(2'h3, 8'h02);
      smp(24'h000010, 24'h000020);
      smp(24'hFFFFF0, 24'h000000);
      @(posedge sys_clk);
      conv_setup_sel <= 2'h2;
      repeat (2) @(posedge sys_clk);
      smp(24'hFFFFF0, 24'h7FFFF0);
      wr_ok(ASCB_IDX_SETUP3, 16'h00A0);
      sel(2'h3, 8'h06);
      open_wire_pin <= 1'b1;
      repeat (4) @(posedge sys_clk);
      smp(24'h000005, 24'hFFFFFF);
      i_ascb_host.rd(ASCB_IDX_STATUS, rdat, resp);
      chk("status", 32'h00000007, rdat);
      chk("rresp status", ASCB_RESP_OKAY, resp);
      open_wire_pin <= 1'b0;
      wr_ok(ASCB_IDX_SETUP3, 16'h0020);
      repeat (4) @(posedge sys_clk);
      smp(24'h000005, 24'h00000A);
      i_ascb_host.wr(6'h3F, 16'h1234, 1'b0, resp);
      chk("bresp unmapped", ASCB_RESP_SLVERR, resp);
      i_ascb_host.wr(ASCB_IDX_STATUS, 16'h0007, 1'b0, resp);
      chk("bresp status", ASCB_RESP_SLVERR, resp);
      i_ascb_host.rd(6'h3F, rdat, resp);
      chk("rresp unmapped", ASCB_RESP_SLVERR, resp);
      chk("rdata unmapped", 32'h00000000, rdat);
      i_ascb_host.rd(ASCB_IDX_SETUP2, rdat, resp);
      chk("setup2", 32'h00001030, rdat);
      end_of_test();
   end
endmodule : tb_ascb_top
